// [icfl_top.sv]
// Input command function logic: gain set switching, up/down adjust, forced panel.
// Assumes terminals arrive asynchronously; drive status and panel signals share the clock.
`timescale 1ns/1ps
`include "icfl_cfg.svh"
module icfl_top
  import icfl_pkg::*;
#(
  parameter int P_MS_CYCLES = `ICFL_MS_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data_ff,
  // Multi-function input terminals
  input wire logic [7:0] i_terminal,
  // Drive status
  input wire logic i_running,
  input wire logic i_multistep,
  input wire logic i_analog_ref,
  input wire logic i_jog_setting,
  input wire logic i_power_restore,
  // Run and frequency sources
  input wire logic i_term_run,
  input wire logic i_panel_run,
  input wire logic [16:0] i_panel_freq,
  // Speed controller
  output logic [16:0] o_kp_ff,
  output logic [16:0] o_ki_ff,
  output logic [16:0] o_kpp_ff,
  output logic [16:0] o_speed_response_ff,
  // Reference selection
  output logic [16:0] o_freq_ref_ff,
  output logic o_run_ff,
  output logic o_panel_override_ff
);
  // Settings
  icfl_word_t method_ff, fsrc_ff, rsrc_ff, store_ff, taper_ff;
  icfl_word_t kp_ff, ki_ff, kpp_ff, akp_ff, aki_ff, akpp_ff, spdrsp_ff, base_ff;
  icfl_word_t rate_ff [3];
  logic [7:0][7:0] assign_ff; // Function code of each terminal
  // Terminal synchroniser and debounced level
  logic [7:0] s1_ff, s2_ff, s3_ff, term_ff;
  // Runtime state
  logic [31:0] div_ff; // Millisecond divider
  logic tick_ff; // One-cycle ms pulse
  logic gsel_ff; // Gain set in use
  logic start_ff; // Starts a taper
  icfl_word_t adj_ff; // Adjusted reference
  icfl_word_t step_ff; // Ms count toward the next ramp step
  icfl_ud_e ud_ff;
  logic cancel_ff;
  logic kp_busy, ki_busy, kpp_busy;
  // Decoded terminal functions
  logic gsel_req, up_on, dn_on, clr_on, set_on, third_control_set_select_on, panel_on, ud_en;
  logic [16:0] wd;
  icfl_word_t rate_sel;

  // True when some terminal carries the code and is on
  function automatic logic fn_on(input logic [7:0][7:0] fa, input logic [7:0] t,
                                 input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = r | ((fa[i] == code) & t[i]);
    end
    return r;
  endfunction

  // Limit a written value into its range
  function automatic icfl_word_t clamp(input icfl_word_t v, input icfl_word_t lo,
                                       input icfl_word_t hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign wd = i_wr_data[16:0];

  // Decoding of the terminals; an unassigned function reads as off
  always_comb begin
    gsel_req = fn_on(assign_ff, term_ff, `ICFL_FN_GAIN);
    up_on = fn_on(assign_ff, term_ff, `ICFL_FN_UP);
    dn_on = fn_on(assign_ff, term_ff, `ICFL_FN_DOWN);
    clr_on = fn_on(assign_ff, term_ff, `ICFL_FN_CLEAR);
    set_on = fn_on(assign_ff, term_ff, `ICFL_FN_SET);
    third_control_set_select_on = fn_on(assign_ff, term_ff, `ICFL_FN_THIRD_CONTROL_SET_SELECT);
    panel_on = fn_on(assign_ff, term_ff, `ICFL_FN_PANEL);
    // Method gate: outside vector control the primary set stays
    if ((method_ff[7:0] < `ICFL_METH_SLV) || (method_ff[7:0] > `ICFL_METH_SENSOR)) begin
      gsel_req = 1'b0;
    end
    ud_en = ((fsrc_ff[7:0] == `ICFL_SRC_PANEL) ||
             ((fsrc_ff[7:0] == `ICFL_SRC_TERM) && i_multistep)) &&
            !i_analog_ref && !i_jog_setting;
    // Third set wins over second, second over first
    rate_sel = third_control_set_select_on ? rate_ff[2] : (set_on ? rate_ff[1] : rate_ff[0]);
  end

  // Terminal synchroniser: a change counts once stages two and three agree
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
      term_ff <= 8'h00;
    end else begin
      s1_ff <= i_terminal;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 8; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          term_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  // Millisecond divider; one pulse per ms drives taper and ramp
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else if (div_ff >= 32'(P_MS_CYCLES - 1)) begin
      div_ff <= 32'h0000_0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
    end
  end

  // Settings writes; ranges are enforced on the way in
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      method_ff <= '0;
      fsrc_ff <= '0;
      rsrc_ff <= '0;
      store_ff <= '0;
      taper_ff <= `ICFL_TAPER_DEF;
      kp_ff <= `ICFL_PI_DEF;
      ki_ff <= `ICFL_PI_DEF;
      kpp_ff <= `ICFL_P_DEF;
      akp_ff <= `ICFL_PI_DEF;
      aki_ff <= `ICFL_PI_DEF;
      akpp_ff <= `ICFL_P_DEF;
      spdrsp_ff <= `ICFL_SR_DEF;
      base_ff <= '0;
      rate_ff <= '{default: '0};
      assign_ff <= '0;
    end else if (i_wr) begin
      if (i_addr == `ICFL_R_METHOD) begin
        method_ff <= {9'h000, wd[7:0]};
      end else if (i_addr == `ICFL_R_FSRC) begin
        fsrc_ff <= {9'h000, wd[7:0]};
      end else if (i_addr == `ICFL_R_RSRC) begin
        rsrc_ff <= {9'h000, wd[7:0]};
      end else if (i_addr == `ICFL_R_STORE) begin
        store_ff <= {9'h000, wd[7:0]};
      end else if (i_addr == `ICFL_R_TAPER) begin
        taper_ff <= clamp(wd, '0, `ICFL_TAPER_MAX);
      end else if (i_addr == `ICFL_R_KP) begin
        kp_ff <= clamp(wd, '0, `ICFL_PI_MAX);
      end else if (i_addr == `ICFL_R_KI) begin
        ki_ff <= clamp(wd, '0, `ICFL_PI_MAX);
      end else if (i_addr == `ICFL_R_KPP) begin
        kpp_ff <= clamp(wd, `ICFL_P_MIN, `ICFL_P_MAX);
      end else if (i_addr == `ICFL_R_AKP) begin
        akp_ff <= clamp(wd, '0, `ICFL_PI_MAX);
      end else if (i_addr == `ICFL_R_AKI) begin
        aki_ff <= clamp(wd, '0, `ICFL_PI_MAX);
      end else if (i_addr == `ICFL_R_AKPP) begin
        akpp_ff <= clamp(wd, '0, `ICFL_P_MAX);
      end else if (i_addr == `ICFL_R_SPDRSP) begin
        // Above 10.000 only hundredths exist, so the last digit drops
        if (clamp(wd, `ICFL_SR_MIN, `ICFL_SR_MAX) >= `ICFL_SR_FINE) begin
          // Truncate the clamped value, so an over-range write still lands on the top
          spdrsp_ff <= clamp(wd, `ICFL_SR_MIN, `ICFL_SR_MAX) -
                       (clamp(wd, `ICFL_SR_MIN, `ICFL_SR_MAX) % 17'h0000A);
        end else begin
          spdrsp_ff <= clamp(wd, `ICFL_SR_MIN, `ICFL_SR_MAX);
        end
      end else if (i_addr == `ICFL_R_BASE) begin
        base_ff <= clamp(wd, '0, `ICFL_FREQ_MAX);
      end else if ((i_addr >= `ICFL_R_RATE1) && (i_addr <= `ICFL_R_RATE3)) begin
        rate_ff[2'(i_addr - `ICFL_R_RATE1)] <= wd;
      end else if ((i_addr >= `ICFL_R_ASSIGN0) && (i_addr < `ICFL_R_STATUS)) begin
        assign_ff[3'(i_addr - `ICFL_R_ASSIGN0)] <= wd[7:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped indices read zero
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data_ff <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rd_data_ff <= 32'h0000_0000;
      if (i_addr == `ICFL_R_METHOD) begin
        o_rd_data_ff[16:0] <= method_ff;
      end else if (i_addr == `ICFL_R_FSRC) begin
        o_rd_data_ff[16:0] <= fsrc_ff;
      end else if (i_addr == `ICFL_R_RSRC) begin
        o_rd_data_ff[16:0] <= rsrc_ff;
      end else if (i_addr == `ICFL_R_STORE) begin
        o_rd_data_ff[16:0] <= store_ff;
      end else if (i_addr == `ICFL_R_TAPER) begin
        o_rd_data_ff[16:0] <= taper_ff;
      end else if (i_addr == `ICFL_R_KP) begin
        o_rd_data_ff[16:0] <= kp_ff;
      end else if (i_addr == `ICFL_R_KI) begin
        o_rd_data_ff[16:0] <= ki_ff;
      end else if (i_addr == `ICFL_R_KPP) begin
        o_rd_data_ff[16:0] <= kpp_ff;
      end else if (i_addr == `ICFL_R_AKP) begin
        o_rd_data_ff[16:0] <= akp_ff;
      end else if (i_addr == `ICFL_R_AKI) begin
        o_rd_data_ff[16:0] <= aki_ff;
      end else if (i_addr == `ICFL_R_AKPP) begin
        o_rd_data_ff[16:0] <= akpp_ff;
      end else if (i_addr == `ICFL_R_SPDRSP) begin
        o_rd_data_ff[16:0] <= spdrsp_ff;
      end else if (i_addr == `ICFL_R_BASE) begin
        o_rd_data_ff[16:0] <= base_ff;
      end else if ((i_addr >= `ICFL_R_RATE1) && (i_addr <= `ICFL_R_RATE3)) begin
        o_rd_data_ff[16:0] <= rate_ff[2'(i_addr - `ICFL_R_RATE1)];
      end else if ((i_addr >= `ICFL_R_ASSIGN0) && (i_addr < `ICFL_R_STATUS)) begin
        o_rd_data_ff[7:0] <= assign_ff[3'(i_addr - `ICFL_R_ASSIGN0)];
      end else if (i_addr == `ICFL_R_STATUS) begin
        o_rd_data_ff[5:0] <= {ud_en, cancel_ff, o_panel_override_ff,
                              kp_busy | ki_busy | kpp_busy, gsel_ff, tick_ff};
      end else if (i_addr == `ICFL_R_ADJ) begin
        o_rd_data_ff[16:0] <= adj_ff;
      end
    end
  end

  // Gain set tracking; a change or a new setting restarts the taper
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gsel_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      gsel_ff <= gsel_req;
      start_ff <= (gsel_req != gsel_ff) ||
                  (i_wr && (i_addr >= `ICFL_R_KP) && (i_addr <= `ICFL_R_AKPP));
    end
  end

  // One taper per gain, all started together so they land together
  icfl_taper #(.W(17), .P_INIT(`ICFL_PI_DEF)) u_kp (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_tick(tick_ff), .i_start(start_ff),
    .i_target(gsel_ff ? akp_ff : kp_ff), .i_time(taper_ff[13:0]),
    .o_value_ff(o_kp_ff), .o_busy_ff(kp_busy));
  icfl_taper #(.W(17), .P_INIT(`ICFL_PI_DEF)) u_ki (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_tick(tick_ff), .i_start(start_ff),
    .i_target(gsel_ff ? aki_ff : ki_ff), .i_time(taper_ff[13:0]),
    .o_value_ff(o_ki_ff), .o_busy_ff(ki_busy));
  icfl_taper #(.W(17), .P_INIT(`ICFL_P_DEF)) u_kpp (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_tick(tick_ff), .i_start(start_ff),
    .i_target(gsel_ff ? akpp_ff : kpp_ff), .i_time(taper_ff[13:0]),
    .o_value_ff(o_kpp_ff), .o_busy_ff(kpp_busy));

  // Speed response passes to the controller registered
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_speed_response_ff <= `ICFL_SR_DEF;
    end else begin
      o_speed_response_ff <= spdrsp_ff;
    end
  end

  // Up/down direction; both on at once holds, a safe reading of a conflict
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ud_ff <= ICFL_UD_HOLD;
    end else if (!ud_en || (up_on == dn_on)) begin
      ud_ff <= ICFL_UD_HOLD;
    end else if (up_on) begin
      ud_ff <= ICFL_UD_UP;
    end else begin
      ud_ff <= ICFL_UD_DOWN;
    end
  end

  // Adjusted reference: ramp one 0.01 Hz step per rate-plus-one ms ticks
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adj_ff <= '0;
      step_ff <= '0;
    end else if (clr_on || (i_wr && (i_addr == `ICFL_R_BASE))) begin
      adj_ff <= clr_on ? base_ff : clamp(wd, '0, `ICFL_FREQ_MAX);
      step_ff <= '0;
    end else if (i_power_restore) begin
      if (store_ff[7:0] != `ICFL_STORE_KEEP) begin
        adj_ff <= base_ff;
      end
      step_ff <= '0;
    end else begin
      case (ud_ff)
        ICFL_UD_UP, ICFL_UD_DOWN: begin
          if (tick_ff) begin
            if (step_ff >= rate_sel) begin
              step_ff <= '0;
              // Release leaves the value where the ramp stopped
              if ((ud_ff == ICFL_UD_UP) && (adj_ff < `ICFL_FREQ_MAX)) begin
                adj_ff <= adj_ff + 17'h00001;
              end else if ((ud_ff == ICFL_UD_DOWN) && (adj_ff != '0)) begin
                adj_ff <= adj_ff - 17'h00001;
              end
            end else begin
              step_ff <= step_ff + 17'h00001;
            end
          end
        end
        default: begin
          step_ff <= '0;
        end
      endcase
    end
  end

  // Forced panel selection and run cancel; a new change beats the release
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_panel_override_ff <= 1'b0;
      cancel_ff <= 1'b0;
    end else begin
      o_panel_override_ff <= panel_on;
      if ((panel_on != o_panel_override_ff) && i_running) begin
        cancel_ff <= 1'b1;
      end else if (!i_term_run && !i_panel_run) begin
        cancel_ff <= 1'b0;
      end
    end
  end

  // Reference and run toward the drive
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_freq_ref_ff <= '0;
      o_run_ff <= 1'b0;
    end else begin
      o_freq_ref_ff <= o_panel_override_ff ? i_panel_freq : adj_ff;
      if (cancel_ff || ((panel_on != o_panel_override_ff) && i_running)) begin
        o_run_ff <= 1'b0;
      end else if (o_panel_override_ff || (rsrc_ff[7:0] == `ICFL_SRC_PANEL)) begin
        o_run_ff <= i_panel_run;
      end else begin
        o_run_ff <= i_term_run;
      end
    end
  end

  a_method_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (method_ff[7:0] < `ICFL_METH_SLV) |=> !gsel_ff)
    else $error("gain set switched outside vector control");
  a_gain_follow: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (gsel_req != gsel_ff) |=> start_ff)
    else $error("gain set change did not start a taper");
  a_taper_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (start_ff && (taper_ff == '0)) |=> !kp_busy)
    else $error("zero taper time did not jump");
  a_taper_land: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(kp_busy) && !$past(start_ff) |-> (o_kp_ff == (gsel_ff ? akp_ff : kp_ff)))
    else $error("taper ended off target");
  a_clear_base: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    clr_on |=> (adj_ff == $past(base_ff)))
    else $error("clear did not restore the base reference");
  a_adjust_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_analog_ref || i_jog_setting) |=> (ud_ff == ICFL_UD_HOLD))
    else $error("adjust active with analog or jog");
  a_override_ref: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_panel_override_ff |=> (o_freq_ref_ff == $past(i_panel_freq)))
    else $error("panel reference not applied");
  a_cancel_run: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ((panel_on != o_panel_override_ff) && i_running) |=> (!o_run_ff && cancel_ff))
    else $error("run not cancelled on forced change");
  a_store_keep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_power_restore && !clr_on && !i_wr && (store_ff[7:0] == `ICFL_STORE_KEEP))
    |=> (adj_ff == $past(adj_ff)))
    else $error("kept adjustment lost at power return");
endmodule

// [icfl_cfg.svh]
// Constants for the input command function logic: offsets, codes, defaults, timing.
// Assumes a single 250 MHz clock and a plain strobe register port.
//
// Function
// - Gain switching only for vector methods 03-05
// - Input code 26 selects the gain set
// - Select off: primary gains; on: alternate gains
// - No input assigned: behave as select off
// - Taper gains over 0-9999 ms, default 100
// - Alternate PI gains 0.0-1000 percent, default 100.0
// - Alternate P gain 0.00-10.00; primary 0.01-10.00
// - Speed response 0.001-9.999 or 10.00-80.00
// - Code 27 raises speed; release holds it
// - Code 28 lowers speed; release keeps it
// - Code 29 clears stored adjustment while on
// - Adjust only for source 02, or 01 multistep
// - No adjust with analog reference or jog
// - Ramp uses rate of set from codes 08/17
// - Option 00 restores base; 01 keeps adjustment
// - Code 31 forces panel frequency and run
// - Forced-source change while running cancels run
`ifndef ICFL_CFG_SVH
`define ICFL_CFG_SVH

// Timing
`define ICFL_CLK_KHZ 250000
`define ICFL_TICK_MS 1
`define ICFL_MS_CYCLES (`ICFL_CLK_KHZ * `ICFL_TICK_MS)

// Register indices
`define ICFL_R_METHOD 5'h00
`define ICFL_R_FSRC 5'h01
`define ICFL_R_RSRC 5'h02
`define ICFL_R_STORE 5'h03
`define ICFL_R_TAPER 5'h04
`define ICFL_R_KP 5'h05
`define ICFL_R_KI 5'h06
`define ICFL_R_KPP 5'h07
`define ICFL_R_AKP 5'h08
`define ICFL_R_AKI 5'h09
`define ICFL_R_AKPP 5'h0A
`define ICFL_R_SPDRSP 5'h0B
`define ICFL_R_BASE 5'h0C
`define ICFL_R_RATE1 5'h0D
`define ICFL_R_RATE2 5'h0E
`define ICFL_R_RATE3 5'h0F
`define ICFL_R_ASSIGN0 5'h10
`define ICFL_R_STATUS 5'h18
`define ICFL_R_ADJ 5'h19

// Input function codes
`define ICFL_FN_SET 8'h08
`define ICFL_FN_THIRD_CONTROL_SET_SELECT 8'h11
`define ICFL_FN_GAIN 8'h1A
`define ICFL_FN_UP 8'h1B
`define ICFL_FN_DOWN 8'h1C
`define ICFL_FN_CLEAR 8'h1D
`define ICFL_FN_PANEL 8'h1F

// Selector codes
`define ICFL_METH_SLV 8'h03
`define ICFL_METH_SENSOR 8'h05
`define ICFL_SRC_TERM 8'h01
`define ICFL_SRC_PANEL 8'h02
`define ICFL_STORE_KEEP 8'h01

// Limits and reset values (gains in 0.1 %, P gain in 0.01, response in 0.001)
`define ICFL_PI_MAX 17'h02710
`define ICFL_PI_DEF 17'h003E8
`define ICFL_P_MAX 17'h003E8
`define ICFL_P_DEF 17'h00064
`define ICFL_P_MIN 17'h00001
`define ICFL_SR_MIN 17'h00001
`define ICFL_SR_MAX 17'h13880
`define ICFL_SR_FINE 17'h02710
`define ICFL_SR_DEF 17'h00636
`define ICFL_TAPER_MAX 17'h0270F
`define ICFL_TAPER_DEF 17'h00064
`define ICFL_FREQ_MAX 17'h09C40

`endif

// [icfl_pkg.sv]
// Types shared by the input command function logic.
// Assumes the constants header is compiled alongside.
package icfl_pkg;
  // Register word held by every setting except the terminal function codes
  typedef logic [16:0] icfl_word_t;
  // Up/down adjustment direction
  typedef enum logic [1:0] {
    ICFL_UD_HOLD = 2'b00,
    ICFL_UD_UP = 2'b01,
    ICFL_UD_DOWN = 2'b10
  } icfl_ud_e;
endpackage

// [icfl_taper.sv]
// Linear taper of one gain from its present value to a new target.
// Assumes a one-cycle millisecond tick from the parent's divider.
`timescale 1ns/1ps
module icfl_taper #(
  parameter int W = 17,
  parameter logic [16:0] P_INIT = 17'h003E8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [W-1:0] i_target,
  input wire logic [13:0] i_time,
  // Result
  output logic [W-1:0] o_value_ff,
  output logic o_busy_ff
);
  logic [W-1:0] tgt_ff; // Value reached at the end
  logic [W-1:0] absd_ff; // Size of the whole change
  logic up_ff; // Direction of the change
  logic [13:0] time_ff; // Taper length in ms
  logic [13:0] elap_ff; // Milliseconds gone by
  logic [W+1:0] acc_ff; // Error accumulator for even spreading
  logic [W+1:0] acc_add;
  logic last;

  // Add the change once per ms, drain one step per time unit
  always_comb begin
    acc_add = acc_ff + ((i_tick) ? {2'b00, absd_ff} : '0);
    last = i_tick && ((elap_ff + 14'h0001) >= time_ff);
  end

  // Taper state; a new start restarts from wherever the output stands
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_value_ff <= P_INIT[W-1:0];
      o_busy_ff <= 1'b0;
      tgt_ff <= P_INIT[W-1:0];
      absd_ff <= '0;
      up_ff <= 1'b0;
      time_ff <= 14'h0000;
      elap_ff <= 14'h0000;
      acc_ff <= '0;
    end else if (i_start) begin
      tgt_ff <= i_target;
      up_ff <= (i_target >= o_value_ff);
      absd_ff <= (i_target >= o_value_ff) ? i_target - o_value_ff : o_value_ff - i_target;
      time_ff <= i_time;
      elap_ff <= 14'h0000;
      acc_ff <= '0;
      // Zero time jumps straight to the target
      if (i_time == 14'h0000) begin
        o_value_ff <= i_target;
        o_busy_ff <= 1'b0;
      end else begin
        o_busy_ff <= 1'b1;
      end
    end else if (o_busy_ff) begin
      if (i_tick) begin
        elap_ff <= elap_ff + 14'h0001;
      end
      // End of taper lands exactly, hiding any rounding left over
      if (last) begin
        o_value_ff <= tgt_ff;
        o_busy_ff <= 1'b0;
        acc_ff <= '0;
      end else if (acc_add >= (W+2)'(time_ff)) begin
        acc_ff <= acc_add - (W+2)'(time_ff);
        o_value_ff <= up_ff ? o_value_ff + 1'b1 : o_value_ff - 1'b1;
      end else begin
        acc_ff <= acc_add;
      end
    end
  end
endmodule

// [icfl_ctrl_model.sv]
// Model of the external controller that drives the terminals and run requests.
// Assumes the bench states what it wants; the model applies it after each clock edge.
`timescale 1ns/1ps
module icfl_ctrl_model (
  // Clock
  input wire logic i_clock,
  // Requests from the bench
  input wire logic [7:0] i_want,
  input wire logic i_run_req,
  input wire logic i_power_off,
  // Terminal side
  output logic [7:0] o_terminal,
  output logic o_term_run,
  output logic o_panel_run
);
  // Terminals freeze while power is off, so a stored reference is never disturbed
  always_ff @(posedge i_clock) begin
    if (!i_power_off) begin
      o_terminal <= i_want;
    end
  end
  // One request drops and raises every run source together
  always_ff @(posedge i_clock) begin
    o_term_run <= i_run_req;
    o_panel_run <= i_run_req;
  end
endmodule

// [tb_icfl_top.sv]
// Self-checking bench for the input command function logic.
// Assumes a 10-cycle millisecond tick so tapers and ramps stay short.
`timescale 1ns/1ps
`include "icfl_cfg.svh"
module tb_icfl_top;
  import icfl_pkg::*;
  logic i_clock, i_rst_n, i_wr, i_rd, i_running, i_analog_ref, i_power_restore;
  logic [4:0] i_addr;
  logic [31:0] i_wr_data, o_rd_data_ff;
  logic [7:0] term, want;
  logic mstep, jog; // Multistep and jog status toward the design
  logic run_req, pwr_off, t_run, p_run, o_run_ff, o_panel_override_ff, rd_d;
  logic [16:0] o_kp_ff, o_ki_ff, o_kpp_ff, o_speed_response_ff, o_freq_ref_ff, akp;
  logic [32:0] q_exp[$];
  int err_total, tests_run;
  icfl_ctrl_model u_ctrl (.i_clock(i_clock), .i_want(want), .i_run_req(run_req),
    .i_power_off(pwr_off), .o_terminal(term), .o_term_run(t_run), .o_panel_run(p_run));
  icfl_top #(.P_MS_CYCLES(10)) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data_ff(o_rd_data_ff),
    .i_terminal(term), .i_running(i_running), .i_multistep(mstep),
    .i_analog_ref(i_analog_ref), .i_jog_setting(jog), .i_power_restore(i_power_restore),
    .i_term_run(t_run), .i_panel_run(p_run), .i_panel_freq(17'h00100), .o_kp_ff(o_kp_ff),
    .o_ki_ff(o_ki_ff), .o_kpp_ff(o_kpp_ff), .o_speed_response_ff(o_speed_response_ff),
    .o_freq_ref_ff(o_freq_ref_ff), .o_run_ff(o_run_ff),
    .o_panel_override_ff(o_panel_override_ff));
  // Free-running 250 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [16:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wr_data <= {15'h0000, d};
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // Bit 32 of a note asks for "greater than" instead of equality
  task automatic rd(input logic [4:0] a, input logic [32:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    q_exp.push_back(e);
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // Bounded wait for the tapered gain to land
  task automatic wait_kp(input logic [16:0] e);
    int n;
    for (n = 0; n < 300 && o_kp_ff !== e; n++) @(posedge i_clock);
    if (n == 300) begin
      err_total++;
      wrap_up();
    end
  endtask
  // Read data stand from the cycle after the read strobe until the next read
  always @(posedge i_clock) begin
    logic [32:0] e;
    rd_d <= i_rd;
    if (rd_d === 1'b1) begin
      e = q_exp.pop_front();
      if (e[32]) chk("adj_gt", {31'h0, o_rd_data_ff > e[31:0]}, 32'h1);
      else chk("rd_data", o_rd_data_ff, e[31:0]);
    end
  end
  // Watchdog so no hang outlives the run
  initial begin
    idle(30000);
    err_total++;
    wrap_up();
  end
  initial begin
    {i_wr, i_rd, i_running, i_analog_ref, i_power_restore, run_req, pwr_off, mstep, jog} = '0;
    {i_addr, i_wr_data, want} = '0;
    err_total = 0;
    tests_run = 0;
    i_rst_n = 1'b0;
    void'($urandom(32'h6e752faf));
    idle(3);
    i_rst_n <= 1'b1;
    idle(1);
    chk("kp", o_kp_ff, `ICFL_PI_DEF);
    chk("kpp", o_kpp_ff, `ICFL_P_DEF);
    chk("ki", o_ki_ff, `ICFL_PI_DEF);
    chk("spd", o_speed_response_ff, `ICFL_SR_DEF);
    rd(`ICFL_R_AKP, `ICFL_PI_DEF);
    rd(5'h1A, 33'h0);
    // Over-range speed response clamps to the top of its range
    wr(`ICFL_R_SPDRSP, 17'h1FFFF);
    rd(`ICFL_R_SPDRSP, {16'h0000, `ICFL_SR_MAX});
    chk("spd_max", o_speed_response_ff, `ICFL_SR_MAX);
    $display("done: reset");
    // Gain set switch with a random alternate gain
    akp = 17'($urandom % 10000);
    wr(`ICFL_R_METHOD, `ICFL_METH_SLV);
    wr(`ICFL_R_TAPER, 17'h00002);
    wr(`ICFL_R_AKP, akp);
    wr(`ICFL_R_ASSIGN0, `ICFL_FN_GAIN);
    want[0] <= 1'b1;
    wait_kp(akp);
    chk("kp_alt", o_kp_ff, akp);
    wr(`ICFL_R_METHOD, 17'h00000);
    wait_kp(`ICFL_PI_DEF);
    chk("kp_meth", o_kp_ff, `ICFL_PI_DEF);
    want[0] <= 1'b0;
    // Zero taper time jumps straight to a newly written gain
    wr(`ICFL_R_TAPER, 17'h00000);
    wr(`ICFL_R_KP, 17'h00200);
    idle(2);
    chk("kp_jump", o_kp_ff, 32'h200);
    $display("done: gain");
    // Up, down, clear, analog lockout and power restore
    wr(`ICFL_R_FSRC, `ICFL_SRC_PANEL);
    wr(`ICFL_R_BASE, 17'h00003);
    wr(`ICFL_R_RATE1, 17'h00000);
    wr(5'h11, `ICFL_FN_UP);
    wr(5'h12, `ICFL_FN_DOWN);
    wr(5'h14, `ICFL_FN_CLEAR);
    want[1] <= 1'b1;
    idle(80);
    want[1] <= 1'b0;
    idle(20);
    rd(`ICFL_R_ADJ, 33'h100000003);
    want[2] <= 1'b1;
    idle(200);
    want[2] <= 1'b0;
    idle(20);
    rd(`ICFL_R_ADJ, 33'h0);
    want[4] <= 1'b1;
    idle(10);
    rd(`ICFL_R_ADJ, 33'h3);
    want[4] <= 1'b0;
    i_analog_ref <= 1'b1;
    want[1] <= 1'b1;
    idle(80);
    rd(`ICFL_R_ADJ, 33'h3);
    i_analog_ref <= 1'b0;
    idle(80);
    want[1] <= 1'b0;
    // Let the released terminal settle before power returns
    idle(10);
    i_power_restore <= 1'b1;
    idle(1);
    i_power_restore <= 1'b0;
    idle(3);
    rd(`ICFL_R_ADJ, 33'h3);
    // Keep option: the adjusted value survives power return
    wr(`ICFL_R_STORE, `ICFL_STORE_KEEP);
    want[1] <= 1'b1;
    idle(40);
    want[1] <= 1'b0;
    idle(10);
    pwr_off <= 1'b1;
    i_power_restore <= 1'b1;
    idle(1);
    i_power_restore <= 1'b0;
    pwr_off <= 1'b0;
    idle(3);
    rd(`ICFL_R_ADJ, 33'h100000003);
    // Terminal source adjusts only in multistep, never while jog is set
    wr(`ICFL_R_FSRC, `ICFL_SRC_TERM);
    wr(`ICFL_R_BASE, 17'h00003);
    want[1] <= 1'b1;
    idle(40);
    rd(`ICFL_R_ADJ, 33'h3);
    mstep <= 1'b1;
    idle(40);
    rd(`ICFL_R_ADJ, 33'h100000003);
    jog <= 1'b1;
    want[4] <= 1'b1;
    idle(10);
    want[4] <= 1'b0;
    idle(40);
    rd(`ICFL_R_ADJ, 33'h3);
    {jog, mstep} <= 2'b00;
    want[1] <= 1'b0;
    $display("done: updown");
    // Forced panel while running
    wr(5'h13, `ICFL_FN_PANEL);
    i_running <= 1'b1;
    run_req <= 1'b1;
    idle(10);
    chk("freq_src", o_freq_ref_ff, 32'h3);
    want[3] <= 1'b1;
    idle(10);
    chk("override", o_panel_override_ff, 32'h1);
    chk("run_cut", o_run_ff, 32'h0);
    chk("freq_panel", o_freq_ref_ff, 32'h100);
    run_req <= 1'b0;
    idle(5);
    run_req <= 1'b1;
    idle(5);
    chk("run_back", o_run_ff, 32'h1);
    $display("done: panel");
    wrap_up();
  end
endmodule
